/* File: common/mcsr_pkg.sv */
// Register map, field positions and constants of the motor control registers
package mcsr_pkg;
  localparam logic [6:0] MCSR_I2C_ADDR = 7'h52;  // Arbitrary bus address
  localparam logic [7:0] MCSR_OFF_SPD_LOW = 8'h00;
  localparam logic [7:0] MCSR_OFF_SPD_HIGH = 8'h01;
  localparam logic [7:0] MCSR_OFF_NVM_UNLOCK = 8'h02;
  localparam logic [7:0] MCSR_OFF_NVM_CONTROL = 8'h03;
  localparam logic [7:0] MCSR_OFF_FAULT_FLAGS = 8'h10;
  localparam int MCSR_BIT_TAKEOVER = 7;
  localparam int MCSR_BIT_SPD_MSB = 0;
  localparam int MCSR_BIT_INHIBIT = 7;
  localparam int MCSR_BIT_CFG_WE = 6;
  localparam int MCSR_BIT_RELOAD = 5;
  localparam int MCSR_BIT_PROGRAM = 4;
  localparam int MCSR_BIT_THERMAL = 7;
  localparam int MCSR_BIT_LOWPWR = 6;
  localparam int MCSR_BIT_OVERCUR = 5;
  localparam int MCSR_BIT_LOCKED = 4;
  localparam logic [7:0] MCSR_UNLOCK_KEY = 8'hB6;
  localparam logic [7:0] MCSR_RST_BYTE = 8'h00;
  localparam logic [8:0] MCSR_RST_SPEED = 9'h000;
endpackage

/* File: rtl/mcsr_sync.sv */
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module mcsr_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } mcsr_sync_t;
  mcsr_sync_t st_reg, st_next;
  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign q = st_reg.s2;
endmodule // mcsr_sync

/* File: rtl/mcsr_i2c_slave.sv */
// I2C target: byte-wide register pointer, write and read strobes
`timescale 1ns/1ps
module mcsr_i2c_slave
  import mcsr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  typedef enum logic [2:0] {
    MCSR_IDLE, MCSR_DEVADR, MCSR_ACK, MCSR_RXB, MCSR_TXB, MCSR_MACK
  } mcsr_ist_t;
  typedef struct packed {
    mcsr_ist_t st;
    logic scl_d;
    logic sda_d;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rnw;
    logic first;
    logic oe;
    logic [7:0] ptr;
    logic wr;
    logic rd;
    logic [7:0] wd;
  } mcsr_i2c_t;
  mcsr_i2c_t s_reg, s_next;
  logic scl_s, sda_s, rise, fall, start, stop;
  mcsr_sync u_scl (.mclk(mclk), .rst(rst), .d(scl), .q(scl_s));
  mcsr_sync u_sda (.mclk(mclk), .rst(rst), .d(sda_in), .q(sda_s));
  assign rise = scl_s & ~s_reg.scl_d;
  assign fall = ~scl_s & s_reg.scl_d;
  assign start = scl_s & s_reg.scl_d & s_reg.sda_d & ~sda_s;
  assign stop = scl_s & s_reg.scl_d & ~s_reg.sda_d & sda_s;
  always_comb begin
    s_next = s_reg;
    s_next.scl_d = scl_s;
    s_next.sda_d = sda_s;
    s_next.wr = 1'b0;
    s_next.rd = 1'b0;
    if (start) begin
      s_next.st = MCSR_DEVADR;
      s_next.cnt = 4'h0;
      s_next.oe = 1'b0;
    end else if (stop) begin
      s_next.st = MCSR_IDLE;
      s_next.oe = 1'b0;
    end else begin
      unique case (s_reg.st)
        MCSR_IDLE: ;
        MCSR_DEVADR, MCSR_RXB: begin
          if (rise) begin
            s_next.sh = {s_reg.sh[6:0], sda_s};
            s_next.cnt = s_reg.cnt + 4'h1;
          end
          if (fall && s_reg.cnt == 4'h8) begin
            s_next.cnt = 4'h0;
            if (s_reg.st == MCSR_DEVADR) begin
              if (s_reg.sh[7:1] == MCSR_I2C_ADDR) begin
                s_next.rnw = s_reg.sh[0];
                s_next.first = 1'b1;
                s_next.oe = 1'b1;
                s_next.st = MCSR_ACK;
              end else begin
                s_next.st = MCSR_IDLE;
              end
            end else begin
              s_next.oe = 1'b1;
              s_next.st = MCSR_ACK;
              if (s_reg.first) begin
                s_next.ptr = s_reg.sh;
                s_next.first = 1'b0;
              end else begin
                s_next.wd = s_reg.sh;
                s_next.wr = 1'b1;
              end
            end
          end
        end
        MCSR_ACK: begin
          if (fall) begin
            if (s_reg.rnw) begin
              // Load read byte; a read strobe lets status clear on read
              s_next.sh = rdata;
              s_next.rd = 1'b1;
              s_next.oe = ~rdata[7];
              s_next.st = MCSR_TXB;
              s_next.cnt = 4'h1;
            end else begin
              s_next.oe = 1'b0;
              s_next.st = MCSR_RXB;
            end
          end
        end
        MCSR_TXB: begin
          if (fall) begin
            if (s_reg.cnt == 4'h8) begin
              s_next.oe = 1'b0;
              s_next.st = MCSR_MACK;
              s_next.ptr = s_reg.ptr + 8'h01;
            end else begin
              s_next.sh = {s_reg.sh[6:0], 1'b0};
              s_next.oe = ~s_reg.sh[6];
              s_next.cnt = s_reg.cnt + 4'h1;
            end
          end
        end
        MCSR_MACK: begin
          if (rise) begin
            s_next.st = sda_s ? MCSR_IDLE : MCSR_ACK;
          end
        end
        default: s_next.st = MCSR_IDLE;
      endcase
    end
    if (s_reg.wr) begin
      s_next.ptr = s_reg.ptr + 8'h01;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: MCSR_IDLE, scl_d: 1'b1, sda_d: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = s_reg.oe;
  assign wr_stb = s_reg.wr;
  assign rd_stb = s_reg.rd;
  assign addr = s_reg.ptr;
  assign wdata = s_reg.wd;
endmodule // mcsr_i2c_slave

/* File: rtl/mcsr_regs.sv */
// Control and status registers of the motor driver, reached over I2C
// Functional notes
// - Nine-bit speed command: low byte at 0x00, top bit at 0x01 bit 0.
// - Takeover bit at 0x01 bit 7 selects host speed command.
// - Low byte write snapshots stored top bit; nine bits apply together.
// - Key 0xB6 at 0x02 then program bit immediately enables programming.
// - Key not immediately followed by program bit is cleared.
// - Bit 7 of 0x03 inhibits sleep or standby.
// - Configuration writes allowed only while 0x03 bit 6 is set.
// - Reload bit copies non-volatile contents into configuration registers.
// - Program bit after valid unlock writes configuration to non-volatile.
// - Status bit 7 high while die is over temperature.
// - Status bit 6 shows sleep or standby entered.
// - Status bit 5 sticky on overcurrent event.
// - Reading status clears overcurrent flag; set again only on new event.
// - Status bit 4 high while rotor lock is detected.
`timescale 1ns/1ps
module mcsr_regs
  import mcsr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic thermal_in,
  input wire logic low_power_in,
  input wire logic overcurrent_in,
  input wire logic rotor_lock_in,
  input wire logic [8:0] pin_speed,
  output logic [8:0] speed_command_value,
  output logic host_speed_takeover,
  output logic low_power_inhibit,
  output logic cfg_write_enable,
  output logic nvm_reload,
  output logic nvm_program
);
  typedef struct packed {
    logic [7:0] spd_low;
    logic spd_msb;
    logic takeover;
    logic [8:0] spd_eff;
    logic [7:0] key;
    logic inhibit;
    logic cfg_we;
    logic reload;
    logic prog;
    logic thermal;
    logic lowpwr;
    logic overcur;
    logic locked;
    logic oc_d;
    logic sda_oe;
  } mcsr_regs_t;
  mcsr_regs_t r_reg, r_next;
  logic wr_stb, rd_stb, i2c_oe;
  logic [7:0] addr, wdata, rdata;
  logic thermal_s, lowpwr_s, oc_s, lock_s;
  logic [8:0] spd_hold;
  logic oc_rise, key_ok;

  mcsr_sync u_s0 (.mclk(mclk), .rst(rst), .d(thermal_in), .q(thermal_s));
  mcsr_sync u_s1 (.mclk(mclk), .rst(rst), .d(low_power_in), .q(lowpwr_s));
  mcsr_sync u_s2 (.mclk(mclk), .rst(rst), .d(overcurrent_in), .q(oc_s));
  mcsr_sync u_s3 (.mclk(mclk), .rst(rst), .d(rotor_lock_in), .q(lock_s));

  // Pin speed is a slow analog/PWM result; hold it through two flops too
  logic [8:0] pin_m_reg, pin_s_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_m_reg <= MCSR_RST_SPEED;
      pin_s_reg <= MCSR_RST_SPEED;
    end else begin
      pin_m_reg <= pin_speed;
      pin_s_reg <= pin_m_reg;
    end
  end
  assign spd_hold = pin_s_reg;

  mcsr_i2c_slave u_i2c (
    .mclk(mclk),
    .rst(rst),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(),
    .sda_oe(i2c_oe),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .addr(addr),
    .wdata(wdata),
    .rdata(rdata)
  );

  // Read mux; unused bits zero
  always_comb begin
    rdata = 8'h00;
    unique case (addr)
      MCSR_OFF_SPD_LOW: rdata = r_reg.spd_low;
      MCSR_OFF_SPD_HIGH: begin
        rdata[MCSR_BIT_TAKEOVER] = r_reg.takeover;
        rdata[MCSR_BIT_SPD_MSB] = r_reg.spd_msb;
      end
      MCSR_OFF_NVM_UNLOCK: rdata = r_reg.key;
      MCSR_OFF_NVM_CONTROL: begin
        rdata[MCSR_BIT_INHIBIT] = r_reg.inhibit;
        rdata[MCSR_BIT_CFG_WE] = r_reg.cfg_we;
        rdata[MCSR_BIT_RELOAD] = r_reg.reload;
        rdata[MCSR_BIT_PROGRAM] = r_reg.prog;
      end
      MCSR_OFF_FAULT_FLAGS: begin
        rdata[MCSR_BIT_THERMAL] = r_reg.thermal;
        rdata[MCSR_BIT_LOWPWR] = r_reg.lowpwr;
        rdata[MCSR_BIT_OVERCUR] = r_reg.overcur;
        rdata[MCSR_BIT_LOCKED] = r_reg.locked;
      end
      default: rdata = 8'h00;
    endcase
  end

  assign oc_rise = oc_s & ~r_reg.oc_d;
  assign key_ok = (r_reg.key == MCSR_UNLOCK_KEY);

  always_comb begin
    r_next = r_reg;
    r_next.oc_d = oc_s;
    r_next.reload = 1'b0;
    r_next.prog = 1'b0;
    r_next.sda_oe = i2c_oe;
    r_next.thermal = thermal_s;
    r_next.lowpwr = lowpwr_s & ~r_reg.inhibit;
    r_next.locked = lock_s;
    if (wr_stb) begin
      // Any write drops the key, the program bit write included; a write to 0x02 loads a new one
      if (r_reg.key != 8'h00) begin
        r_next.key = 8'h00;
      end
      unique case (addr)
        MCSR_OFF_SPD_LOW: begin
          r_next.spd_low = wdata;
          r_next.spd_eff = {r_reg.spd_msb, wdata};
        end
        MCSR_OFF_SPD_HIGH: begin
          r_next.takeover = wdata[MCSR_BIT_TAKEOVER];
          r_next.spd_msb = wdata[MCSR_BIT_SPD_MSB];
        end
        MCSR_OFF_NVM_UNLOCK: r_next.key = wdata;
        MCSR_OFF_NVM_CONTROL: begin
          r_next.inhibit = wdata[MCSR_BIT_INHIBIT];
          r_next.cfg_we = wdata[MCSR_BIT_CFG_WE];
          r_next.reload = wdata[MCSR_BIT_RELOAD];
          r_next.prog = wdata[MCSR_BIT_PROGRAM] & key_ok;
        end
        default: ;
      endcase
    end
    // Event wins over read clear
    if (rd_stb && addr == MCSR_OFF_FAULT_FLAGS) begin
      r_next.overcur = 1'b0;
    end
    if (oc_rise) begin
      r_next.overcur = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Takeover selects the host value, else the pin-derived command
  logic [8:0] spd_out_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      spd_out_reg <= MCSR_RST_SPEED;
    end else begin
      spd_out_reg <= r_reg.takeover ? r_reg.spd_eff : spd_hold;
    end
  end

  assign speed_command_value = spd_out_reg;
  assign host_speed_takeover = r_reg.takeover;
  assign low_power_inhibit = r_reg.inhibit;
  assign cfg_write_enable = r_reg.cfg_we;
  assign nvm_reload = r_reg.reload;
  assign nvm_program = r_reg.prog;
  assign sda_out = 1'b0;
  assign sda_oe = r_reg.sda_oe;

  a_low_byte_snap: assert property (@(posedge mclk) disable iff (rst)
    wr_stb && addr == MCSR_OFF_SPD_LOW |=>
      r_reg.spd_eff == {$past(r_reg.spd_msb), $past(wdata)})
    else $error("speed snapshot wrong");
  a_msb_no_apply: assert property (@(posedge mclk) disable iff (rst)
    wr_stb && addr == MCSR_OFF_SPD_HIGH |=> $stable(r_reg.spd_eff))
    else $error("top bit applied without low byte");
  a_takeover_sel: assert property (@(posedge mclk) disable iff (rst)
    r_reg.takeover |=> speed_command_value == $past(r_reg.spd_eff))
    else $error("takeover not honoured");
  a_prog_needs_key: assert property (@(posedge mclk) disable iff (rst)
    nvm_program |-> $past(r_reg.key) == MCSR_UNLOCK_KEY)
    else $error("program without unlock");
  a_key_dropped: assert property (@(posedge mclk) disable iff (rst)
    wr_stb && addr != MCSR_OFF_NVM_UNLOCK |=> r_reg.key == 8'h00)
    else $error("key not cleared");
  a_oc_sticky: assert property (@(posedge mclk) disable iff (rst)
    r_reg.overcur && !(rd_stb && addr == MCSR_OFF_FAULT_FLAGS)
      |=> r_reg.overcur)
    else $error("overcurrent flag lost");
  a_oc_rd_clear: assert property (@(posedge mclk) disable iff (rst)
    rd_stb && addr == MCSR_OFF_FAULT_FLAGS && !oc_rise
      |=> !r_reg.overcur)
    else $error("overcurrent not cleared on read");
  a_inhibit_sleep: assert property (@(posedge mclk) disable iff (rst)
    r_reg.inhibit ##1 r_reg.inhibit |-> !r_reg.lowpwr)
    else $error("low power shown while inhibited");
  a_thermal_flag: assert property (@(posedge mclk) disable iff (rst)
    thermal_s |=> r_reg.thermal)
    else $error("thermal flag missing");
  a_unused_zero: assert property (@(posedge mclk) disable iff (rst)
    addr == MCSR_OFF_FAULT_FLAGS |-> rdata[3:0] == 4'h0)
    else $error("unused status bits nonzero");
  a_reload_pulse: assert property (@(posedge mclk) disable iff (rst)
    nvm_reload |=> !nvm_reload)
    else $error("reload held longer than one cycle");
  a_prog_pulse: assert property (@(posedge mclk) disable iff (rst)
    nvm_program |=> !nvm_program)
    else $error("program held longer than one cycle");
  a_lock_flag: assert property (@(posedge mclk) disable iff (rst)
    lock_s |=> r_reg.locked)
    else $error("rotor lock flag missing");
  a_lowpwr_flag: assert property (@(posedge mclk) disable iff (rst)
    lowpwr_s && !r_reg.inhibit |=> r_reg.lowpwr)
    else $error("low power flag missing");
endmodule // mcsr_regs

/* File: verification/mcsr_host.sv */
// I2C master model standing in for the host controller
`timescale 1ns/1ps
module mcsr_host
  import mcsr_pkg::*;
(
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  // Quarter bit; long enough for the target's synchronisers
  localparam int Q = 5;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic step(input logic c, input logic p);
    repeat (Q) @(negedge mclk);
    scl = c;
    pull = p;
  endtask
  task automatic bit_io(input logic b, output logic r);
    step(1'b0, ~b);
    step(1'b1, ~b);
    repeat (Q) @(negedge mclk);
    r = sda;
    step(1'b0, ~b);
  endtask
  // Ninth bit always released: one-byte reads end with a refusal
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r,
                         output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(1'b1, a);
    ack = ~a;
  endtask
  task automatic start;
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
  task automatic xfer(input logic [6:0] dev, input logic [7:0] off,
                      input logic rd, input logic [7:0] d,
                      output logic [7:0] r, output logic ack);
    logic [7:0] x;
    logic a;
    r = 8'h00;
    start();
    byte_io({dev, 1'b0}, x, ack);
    byte_io(off, x, a);
    ack &= a;
    if (rd) begin
      start();
      byte_io({dev, 1'b1}, x, a);
      ack &= a;
      byte_io(8'hFF, r, a);
    end else begin
      byte_io(d, x, a);
      ack &= a;
    end
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
endmodule // mcsr_host

/* File: verification/motor_ctrl_status_regs_test.sv */
// Self-checking bench for the motor control registers
`timescale 1ns/1ps
module motor_ctrl_status_regs_test
  import mcsr_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic thermal_in = 1'b0;
  logic low_power_in = 1'b0;
  logic overcurrent_in = 1'b0;
  logic rotor_lock_in = 1'b0;
  logic [8:0] pin_speed = 9'h0AA;
  logic scl, pull, sda_out, sda_oe;
  logic [8:0] speed_command_value;
  logic host_speed_takeover, low_power_inhibit, cfg_write_enable;
  logic nvm_reload, nvm_program;
  int err_total = 0;
  int n_tests = 0;
  int n_prog = 0;
  int n_rel = 0;
  // Pull-up: the line is high unless someone pulls it low
  wire sda = ~(pull | sda_oe);
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (nvm_program === 1'b1) n_prog++;
    if (nvm_reload === 1'b1) n_rel++;
  end
  mcsr_host host_u (.mclk(mclk), .sda(sda), .scl(scl), .pull(pull));
  mcsr_regs dut_u (.mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .thermal_in(thermal_in),
    .low_power_in(low_power_in), .overcurrent_in(overcurrent_in),
    .rotor_lock_in(rotor_lock_in), .pin_speed(pin_speed),
    .speed_command_value(speed_command_value),
    .host_speed_takeover(host_speed_takeover),
    .low_power_inhibit(low_power_inhibit),
    .cfg_write_enable(cfg_write_enable), .nvm_reload(nvm_reload),
    .nvm_program(nvm_program));
  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    logic [7:0] r;
    logic a;
    host_u.xfer(MCSR_I2C_ADDR, off, 1'b0, d, r, a);
    chk("ack", 9'h001, {8'h00, a});
  endtask
  task automatic chkrd(input string nm, input logic [7:0] off,
                       input logic [7:0] e);
    logic [7:0] r;
    logic a;
    host_u.xfer(MCSR_I2C_ADDR, off, 1'b1, 8'h00, r, a);
    chk("ack", 9'h001, {8'h00, a});
    chk(nm, {1'b0, e}, {1'b0, r});
  endtask
  task automatic t_reset;
    logic [7:0] r;
    logic a;
    chk("speed", pin_speed, speed_command_value);
    chk("outs", 9'h000, {host_speed_takeover, low_power_inhibit,
      cfg_write_enable, nvm_reload, nvm_program});
    chkrd("low", MCSR_OFF_SPD_LOW, MCSR_RST_BYTE);
    chkrd("high", MCSR_OFF_SPD_HIGH, MCSR_RST_BYTE);
    chkrd("ctl", MCSR_OFF_NVM_CONTROL, MCSR_RST_BYTE);
    wr(8'h07, 8'hFF);
    chkrd("unmapped", 8'h07, 8'h00);
    // Foreign device address must be refused
    host_u.xfer(MCSR_I2C_ADDR ^ 7'h01, 8'h00, 1'b0, 8'h12, r, a);
    chk("nack", 9'h000, {8'h00, a});
  endtask
  task automatic t_speed;
    wr(MCSR_OFF_SPD_HIGH, 8'hFF);
    chk("takeover", 9'h001, {8'h00, host_speed_takeover});
    chk("spd held", MCSR_RST_SPEED, speed_command_value);
    chkrd("high", MCSR_OFF_SPD_HIGH, 8'h81);
    wr(MCSR_OFF_SPD_LOW, 8'h5A);
    chk("spd", 9'h15A, speed_command_value);
    wr(MCSR_OFF_SPD_HIGH, 8'h80);
    chk("spd snap", 9'h15A, speed_command_value);
    wr(MCSR_OFF_SPD_LOW, 8'h33);
    chk("spd", 9'h033, speed_command_value);
    chkrd("low", MCSR_OFF_SPD_LOW, 8'h33);
    wr(MCSR_OFF_SPD_HIGH, 8'h01);
    chk("spd pin", pin_speed, speed_command_value);
  endtask
  task automatic t_nvm;
    wr(MCSR_OFF_NVM_CONTROL, 8'hCF);
    chk("ctl", 9'h003, {7'h00, low_power_inhibit, cfg_write_enable});
    chkrd("ctl", MCSR_OFF_NVM_CONTROL, 8'hC0);
    wr(MCSR_OFF_NVM_UNLOCK, MCSR_UNLOCK_KEY);
    wr(MCSR_OFF_NVM_CONTROL, 8'hD0);
    chk("prog", 9'h001, n_prog[8:0]);
    chkrd("ctl", MCSR_OFF_NVM_CONTROL, 8'hC0);
    wr(MCSR_OFF_NVM_UNLOCK, MCSR_UNLOCK_KEY);
    wr(MCSR_OFF_SPD_HIGH, 8'h00);
    chkrd("key", MCSR_OFF_NVM_UNLOCK, 8'h00);
    wr(MCSR_OFF_NVM_CONTROL, 8'hD0);
    chk("prog", 9'h001, n_prog[8:0]);
    wr(MCSR_OFF_NVM_UNLOCK, 8'hB7);
    wr(MCSR_OFF_NVM_CONTROL, 8'hD0);
    chk("prog", 9'h001, n_prog[8:0]);
    wr(MCSR_OFF_NVM_CONTROL, 8'hE0);
    chk("reload", 9'h001, n_rel[8:0]);
  endtask
  task automatic t_status;
    thermal_in = 1'b1;
    rotor_lock_in = 1'b1;
    low_power_in = 1'b1;
    overcurrent_in = 1'b1;
    repeat (8) @(negedge mclk);
    chkrd("stat", MCSR_OFF_FAULT_FLAGS, 8'hB0);
    // Input still high: only a fresh event may set it again
    chkrd("stat", MCSR_OFF_FAULT_FLAGS, 8'h90);
    overcurrent_in = 1'b0;
    wr(MCSR_OFF_NVM_CONTROL, 8'h40);
    chk("inhibit", 9'h000, {8'h00, low_power_inhibit});
    thermal_in = 1'b0;
    rotor_lock_in = 1'b0;
    repeat (8) @(negedge mclk);
    chkrd("stat", MCSR_OFF_FAULT_FLAGS, 8'h40);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // About 19k cycles are needed; four times that means a hang
  initial begin
    repeat (80000) @(posedge mclk);
    err_total++;
    final_report();
  end
  initial begin
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    repeat (8) @(negedge mclk);
    t_reset();
    t_speed();
    t_nvm();
    t_status();
    final_report();
  end
endmodule // motor_ctrl_status_regs_test
